// ---- common/cycle_watch_pkg.sv ----
// shared constants and types for the cycle-time watchdog
package cycle_watch_pkg;
    // ---------------------------------------------------------------
    // clock and time base
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_TIME_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_TIME_MS;
    // ---------------------------------------------------------------
    // limits; CEIL_MS, DEFAULT_MS and STEP_MS in ms, the other two in STEP_MS units
    // ---------------------------------------------------------------
    localparam logic [15:0] CEIL_MS = 16'h03E8;
    localparam logic [15:0] DEFAULT_MS = 16'h03E8;
    localparam logic [15:0] STEP_MS = 16'h000A;
    localparam logic [15:0] EXT_MAX_SETTING = 16'h0064;
    localparam logic [11:0] USER_MAX_CODE = 12'hFA0;
    // ---------------------------------------------------------------
    // register map, byte addresses
    // ---------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] USER_LIMIT_OFS = 8'h04;
    localparam logic [7:0] MAX_CYCLE_OFS = 8'h08;
    localparam logic [7:0] PRESENT_CYCLE_OFS = 8'h0C;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h10;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h14;
    localparam logic [7:0] FLAGS_OFS = 8'h18;
    localparam logic [7:0] EXT_TOTAL_OFS = 8'h1C;
    // ---------------------------------------------------------------
    // fields and reset values
    // ---------------------------------------------------------------
    localparam int CTRL_SEL_BIT = 0;
    localparam int EV_OVERRUN = 0;
    localparam int EV_EXT_ERR = 1;
    localparam int EV_CYCLE_END = 2;
    localparam int FLAG_FATAL = 0;
    localparam int FLAG_INSTR_ERR = 1;
    localparam logic CTRL_SEL_RST = 1'b0;
    localparam logic [11:0] USER_LIMIT_RST = 12'h064;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic strobe;
        logic [15:0] setting;
    } ext_cmd_s;

    typedef struct packed {
        logic watch_sel;
        logic [11:0] user_lim;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [15:0] ext_ms;
        logic [31:0] elapsed;
        logic [31:0] present;
        logic [31:0] maxc;
        logic fatal;
        logic ierr;
        logic irq;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } watch_state_s;
endpackage

// ---- verilog/ms_tick_divider.sv ----
// divider making a one-cycle enable pulse every DIV clocks
module ms_tick_divider #(
    parameter int DIV = 40000
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic restart_in,
    output logic tick_out
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic tick_next;

    always_comb begin
        cnt_next = cnt_reg + 32'h1;
        tick_next = 1'b0;
        // restart aligns the first tick to the cycle boundary
        if (restart_in || cnt_reg == 32'(DIV - 1)) begin
            cnt_next = 32'h0;
        end
        if (!restart_in && cnt_reg == 32'(DIV - 1)) begin
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_reg <= 32'h0;
            tick_out <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_out <= tick_next;
        end
    end
endmodule

// ---- verilog/cycle_time_watchdog_extend.sv ----
// cycle-time watchdog with per-cycle limit extension and AXI4-Lite registers
module cycle_time_watchdog_extend #(
    parameter int MS_DIV = cycle_watch_pkg::TICK_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cycle_start_in,
    input wire cycle_watch_pkg::ext_cmd_s cycle_extend_cmd_in,
    output logic overrun_fatal_flag_out,
    output logic instruction_error_flag_out,
    output logic halt_out,
    output logic irq_out,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in
);
    cycle_watch_pkg::watch_state_s s_reg;
    cycle_watch_pkg::watch_state_s s_next;
    logic tick;
    logic [15:0] user_ms;
    logic [15:0] base_ms;
    logic [15:0] limit_ms;
    logic [15:0] room_ms;
    logic [19:0] req_ms;
    logic [11:0] user_code;
    logic overrun;
    logic [2:0] ev_set;

    // ---------------------------------------------------------------
    // time base
    // ---------------------------------------------------------------
    ms_tick_divider #(
        .DIV(MS_DIV)
    ) u_tick (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .restart_in(cycle_start_in),
        .tick_out(tick)
    );

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ---------------------------------------------------------------
    // limit arithmetic
    // ---------------------------------------------------------------
    always_comb begin
        // code 0 is outside the legal span, treated as one unit
        user_code = (s_reg.user_lim == 12'h000) ? 12'h001 : s_reg.user_lim;
        user_ms = 16'({4'h0, user_code} * cycle_watch_pkg::STEP_MS);
        if (user_ms > cycle_watch_pkg::CEIL_MS) begin
            user_ms = cycle_watch_pkg::CEIL_MS;
        end
        base_ms = s_reg.watch_sel ? user_ms : cycle_watch_pkg::DEFAULT_MS;
        limit_ms = base_ms + s_reg.ext_ms;
        // a base change in mid-cycle must not lift the limit past the ceiling
        if (limit_ms > cycle_watch_pkg::CEIL_MS) begin
            limit_ms = cycle_watch_pkg::CEIL_MS;
        end
        room_ms = (limit_ms >= cycle_watch_pkg::CEIL_MS) ? 16'h0000
                : cycle_watch_pkg::CEIL_MS - limit_ms;
        req_ms = {4'h0, cycle_extend_cmd_in.setting} * {4'h0, cycle_watch_pkg::STEP_MS};
        overrun = s_reg.elapsed > {16'h0000, limit_ms};
        // events raised this cycle, kept apart so that a clear cannot undo them
        ev_set = 3'h0;
        ev_set[cycle_watch_pkg::EV_OVERRUN] = overrun && !s_reg.fatal;
        ev_set[cycle_watch_pkg::EV_EXT_ERR] = cycle_extend_cmd_in.strobe
            && cycle_extend_cmd_in.setting > cycle_watch_pkg::EXT_MAX_SETTING;
        ev_set[cycle_watch_pkg::EV_CYCLE_END] = cycle_start_in && !s_reg.fatal;
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        // watchdog core
        if (overrun && !s_reg.fatal) begin
            s_next.fatal = 1'b1;
            s_next.irq_stat[cycle_watch_pkg::EV_OVERRUN] = 1'b1;
        end
        if (cycle_extend_cmd_in.strobe) begin
            s_next.ierr = cycle_extend_cmd_in.setting > cycle_watch_pkg::EXT_MAX_SETTING;
            if (s_next.ierr) begin
                s_next.irq_stat[cycle_watch_pkg::EV_EXT_ERR] = 1'b1;
            end
            // clipped to the room left under the ceiling; zero room adds nothing
            if (req_ms > {4'h0, room_ms}) begin
                s_next.ext_ms = s_reg.ext_ms + room_ms;
            end else begin
                s_next.ext_ms = s_reg.ext_ms + req_ms[15:0];
            end
        end
        if (!s_reg.fatal) begin
            if (cycle_start_in) begin
                s_next.present = s_reg.elapsed;
                if (s_reg.elapsed > s_reg.maxc) begin
                    s_next.maxc = s_reg.elapsed;
                end
                // a boundary drops any extension, even one arriving now
                s_next.elapsed = 32'h0;
                s_next.ext_ms = 16'h0000;
                s_next.irq_stat[cycle_watch_pkg::EV_CYCLE_END] = 1'b1;
            end else if (tick && s_reg.elapsed != 32'hFFFFFFFF) begin
                s_next.elapsed = s_reg.elapsed + 32'h1;
            end
        end

        // write channel
        if (s_axi_awvalid_in && s_reg.awready) begin
            s_next.aw_got = 1'b1;
            s_next.awaddr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_reg.wready) begin
            s_next.w_got = 1'b1;
            s_next.wdata = s_axi_wdata_in;
            s_next.wstrb = s_axi_wstrb_in;
        end
        if (s_reg.bvalid && s_axi_bready_in) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = cycle_watch_pkg::RESP_OKAY;
            unique case (s_reg.awaddr)
                cycle_watch_pkg::CTRL_OFS: begin
                    if (s_reg.wstrb[0]) begin
                        s_next.watch_sel = s_reg.wdata[cycle_watch_pkg::CTRL_SEL_BIT];
                    end
                end
                cycle_watch_pkg::USER_LIMIT_OFS: begin
                    s_next.user_lim = 12'(merge({20'h0, s_reg.user_lim}, s_reg.wdata,
                                                s_reg.wstrb));
                end
                cycle_watch_pkg::IRQ_STATUS_OFS: begin
                    // a new event in this cycle wins over the clear
                    if (s_reg.wstrb[0]) begin
                        s_next.irq_stat = s_next.irq_stat & ~(s_reg.wdata[2:0] & ~ev_set);
                    end
                end
                cycle_watch_pkg::IRQ_MASK_OFS: begin
                    if (s_reg.wstrb[0]) begin
                        s_next.irq_mask = s_reg.wdata[2:0];
                    end
                end
                cycle_watch_pkg::MAX_CYCLE_OFS, cycle_watch_pkg::PRESENT_CYCLE_OFS,
                cycle_watch_pkg::FLAGS_OFS, cycle_watch_pkg::EXT_TOTAL_OFS: begin
                end
                default: begin
                    s_next.bresp = cycle_watch_pkg::RESP_SLVERR;
                end
            endcase
        end
        s_next.awready = !s_next.aw_got && !s_next.bvalid;
        s_next.wready = !s_next.w_got && !s_next.bvalid;

        // read channel
        if (s_reg.rvalid && s_axi_rready_in) begin
            s_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && s_reg.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = cycle_watch_pkg::RESP_OKAY;
            unique case (s_axi_araddr_in)
                cycle_watch_pkg::CTRL_OFS: s_next.rdata = {31'h0, s_reg.watch_sel};
                cycle_watch_pkg::USER_LIMIT_OFS: s_next.rdata = {20'h0, s_reg.user_lim};
                cycle_watch_pkg::MAX_CYCLE_OFS: s_next.rdata = s_reg.maxc;
                cycle_watch_pkg::PRESENT_CYCLE_OFS: s_next.rdata = s_reg.present;
                cycle_watch_pkg::IRQ_STATUS_OFS: s_next.rdata = {29'h0, s_reg.irq_stat};
                cycle_watch_pkg::IRQ_MASK_OFS: s_next.rdata = {29'h0, s_reg.irq_mask};
                cycle_watch_pkg::FLAGS_OFS: s_next.rdata = {30'h0, s_reg.ierr, s_reg.fatal};
                cycle_watch_pkg::EXT_TOTAL_OFS: s_next.rdata = {16'h0, s_reg.ext_ms};
                default: begin
                    s_next.rdata = 32'h0;
                    s_next.rresp = cycle_watch_pkg::RESP_SLVERR;
                end
            endcase
        end
        s_next.arready = !s_next.rvalid;
        s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_reg <= '0;
            s_reg.watch_sel <= cycle_watch_pkg::CTRL_SEL_RST;
            s_reg.user_lim <= cycle_watch_pkg::USER_LIMIT_RST;
            s_reg.irq_mask <= cycle_watch_pkg::IRQ_MASK_RST;
            s_reg.awready <= 1'b1;
            s_reg.wready <= 1'b1;
            s_reg.arready <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    always_comb begin
        overrun_fatal_flag_out = s_reg.fatal;
        halt_out = s_reg.fatal;
        instruction_error_flag_out = s_reg.ierr;
        irq_out = s_reg.irq;
        s_axi_awready_out = s_reg.awready;
        s_axi_wready_out = s_reg.wready;
        s_axi_bvalid_out = s_reg.bvalid;
        s_axi_bresp_out = s_reg.bresp;
        s_axi_arready_out = s_reg.arready;
        s_axi_rvalid_out = s_reg.rvalid;
        s_axi_rdata_out = s_reg.rdata;
        s_axi_rresp_out = s_reg.rresp;
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    logic start_ok;
    logic cmd_only;
    assign start_ok = cycle_start_in && !s_reg.fatal;
    assign cmd_only = cycle_extend_cmd_in.strobe && !cycle_start_in;

    sequence s_boundary;
        start_ok;
    endsequence
    sequence s_fresh_cycle;
        s_reg.ext_ms == 16'h0000 && s_reg.elapsed == 32'h0;
    endsequence

    property p_restart;
        s_boundary |=> s_fresh_cycle;
    endproperty
    a_restart: assert property (p_restart) else $error("cycle start did not restart");

    property p_revert;
        s_boundary ##1 !cycle_extend_cmd_in.strobe |-> base_ms == limit_ms;
    endproperty
    a_revert: assert property (p_revert) else $error("extension leaked to next cycle");

    property p_err_set;
        cycle_extend_cmd_in.strobe && cycle_extend_cmd_in.setting > 16'h0064
            |=> instruction_error_flag_out;
    endproperty
    a_err_set: assert property (p_err_set) else $error("oversize request not flagged");

    property p_err_clr;
        cycle_extend_cmd_in.strobe && cycle_extend_cmd_in.setting <= 16'h0064
            |=> !instruction_error_flag_out;
    endproperty
    a_err_clr: assert property (p_err_clr) else $error("error flag not cleared");

    property p_cap;
        limit_ms <= 16'd1000;
    endproperty
    a_cap: assert property (p_cap) else $error("limit above ceiling");

    property p_add;
        cmd_only && req_ms <= {4'h0, room_ms} |=> s_reg.ext_ms == $past(s_reg.ext_ms)
            + $past(cycle_extend_cmd_in.setting) * 16'd10;
    endproperty
    a_add: assert property (p_add) else $error("extension not added");

    property p_clip;
        cmd_only && req_ms > {4'h0, room_ms} |=> limit_ms == 16'd1000;
    endproperty
    a_clip: assert property (p_clip) else $error("clipped extension wrong");

    property p_full;
        cmd_only && limit_ms == 16'd1000 |=> $stable(s_reg.ext_ms);
    endproperty
    a_full: assert property (p_full) else $error("extension past full limit");

    property p_default;
        !s_reg.watch_sel |-> base_ms == 16'd1000;
    endproperty
    a_default: assert property (p_default) else $error("default limit wrong");

    property p_user;
        s_reg.watch_sel && s_reg.user_lim == 12'h032 |-> base_ms == 16'd500;
    endproperty
    a_user: assert property (p_user) else $error("user limit wrong");

    property p_overrun;
        overrun |=> overrun_fatal_flag_out && halt_out ##1 halt_out;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not fatal");

    property p_present;
        s_boundary |=> s_reg.present == $past(s_reg.elapsed) && s_reg.maxc >= s_reg.present;
    endproperty
    a_present: assert property (p_present) else $error("cycle times not recorded");

    property p_max;
        s_boundary ##1 s_reg.present > $past(s_reg.maxc) |-> s_reg.maxc == s_reg.present;
    endproperty
    a_max: assert property (p_max) else $error("max cycle not raised");
endmodule

// ---- dv/test_cycle_time_watchdog_extend.sv ----
// self-checking testbench for the cycle-time watchdog with per-cycle extension
module test_cycle_time_watchdog_extend;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    // four clocks per ms keeps a 1000 ms cycle short; all times below are in ms
    localparam int DIV = 4;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic start_pulse = 1'b0;
    cycle_watch_pkg::ext_cmd_s ext_cmd = '0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic fatal, ierr, halt, irq, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int err_total = 0;
    int tests_run = 0;

    always #12.5 clk_in = ~clk_in;

    cycle_time_watchdog_extend #(.MS_DIV(DIV)) dut_u (
        .clk_in(clk_in), .rst_in(rst_in), .cycle_start_in(start_pulse),
        .cycle_extend_cmd_in(ext_cmd), .overrun_fatal_flag_out(fatal),
        .instruction_error_flag_out(ierr), .halt_out(halt), .irq_out(irq),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));

    // ----------------------------------------------------------------
    // reporting
    // ----------------------------------------------------------------
    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic fail;
        err_total++;
        end_of_test;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // tick rounding at the boundaries may shift a duration by one ms
    task automatic near(input logic [31:0] seen, input int lo, input int hi);
        check({31'h0, (seen >= lo && seen <= hi)}, 32'h1);
    endtask

    // ----------------------------------------------------------------
    // bus and stimulus helpers
    // ----------------------------------------------------------------
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 100) begin
            @(posedge clk_in);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (bvalid !== 1'b1) fail();
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 100) begin
            @(posedge clk_in);
            n++;
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (rvalid !== 1'b1) fail();
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check(d, exp);
    endtask

    task automatic start_cycle;
        @(posedge clk_in);
        start_pulse <= 1'b1;
        @(posedge clk_in);
        start_pulse <= 1'b0;
        @(posedge clk_in);
    endtask

    // the trailing edge lets the registered flag settle before anyone looks
    task automatic extend(input logic [15:0] s);
        @(posedge clk_in);
        ext_cmd.strobe <= 1'b1;
        ext_cmd.setting <= s;
        @(posedge clk_in);
        ext_cmd.strobe <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic wait_ms(input int k);
        repeat (k * DIV) @(posedge clk_in);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_values;
        logic [31:0] d;
        logic [1:0] r;
        rd_check(cycle_watch_pkg::CTRL_OFS, 32'h0);
        rd_check(cycle_watch_pkg::USER_LIMIT_OFS, 32'h64);
        rd_check(cycle_watch_pkg::FLAGS_OFS, 32'h0);
        rd_check(cycle_watch_pkg::IRQ_MASK_OFS, 32'h0);
        axi_read(8'h40, d, r);
        check({30'h0, r}, {30'h0, cycle_watch_pkg::RESP_SLVERR});
        axi_write(cycle_watch_pkg::MAX_CYCLE_OFS, 32'hFFFF, r);
        check({30'h0, r}, {30'h0, cycle_watch_pkg::RESP_OKAY});
        rd_check(cycle_watch_pkg::MAX_CYCLE_OFS, 32'h0);
    endtask

    // select 0 ignores the 500 ms user limit, so a 700 ms cycle is legal
    task automatic t_times;
        logic [31:0] d;
        logic [1:0] r;
        axi_write(cycle_watch_pkg::USER_LIMIT_OFS, 32'h32, r);
        start_cycle;
        wait_ms(700);
        start_cycle;
        check({31'h0, fatal}, 32'h0);
        axi_read(cycle_watch_pkg::PRESENT_CYCLE_OFS, d, r);
        near(d, 699, 701);
        wait_ms(300);
        start_cycle;
        axi_read(cycle_watch_pkg::PRESENT_CYCLE_OFS, d, r);
        near(d, 299, 302);
        axi_read(cycle_watch_pkg::MAX_CYCLE_OFS, d, r);
        near(d, 699, 701);
    endtask

    task automatic t_extend;
        logic [1:0] r;
        axi_write(cycle_watch_pkg::CTRL_OFS, 32'h1, r);
        start_cycle;
        extend(16'h001E);
        rd_check(cycle_watch_pkg::EXT_TOTAL_OFS, 32'h12C);
        extend(16'h0032);
        rd_check(cycle_watch_pkg::EXT_TOTAL_OFS, 32'h1F4);
        extend(16'h0001);
        rd_check(cycle_watch_pkg::EXT_TOTAL_OFS, 32'h1F4);
        extend(16'h0065);
        check({31'h0, ierr}, 32'h1);
        extend(16'h0064);
        check({31'h0, ierr}, 32'h0);
        start_cycle;
        rd_check(cycle_watch_pkg::EXT_TOTAL_OFS, 32'h0);
        extend(16'h000A);
        extend(16'h0014);
        rd_check(cycle_watch_pkg::EXT_TOTAL_OFS, 32'h12C);
    endtask

    // an extended 700 ms cycle passes, the plain 500 ms one after it overruns
    task automatic t_overrun;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        axi_write(cycle_watch_pkg::IRQ_MASK_OFS, 32'h1, r);
        start_cycle;
        extend(16'h0032);
        wait_ms(700);
        check({31'h0, fatal}, 32'h0);
        start_cycle;
        n = 0;
        while (fatal !== 1'b1 && n < 600 * DIV) begin
            @(posedge clk_in);
            n++;
        end
        if (fatal !== 1'b1) fail();
        near(n / DIV, 500, 502);
        repeat (3) @(posedge clk_in);
        check({31'h0, halt}, 32'h1);
        check({31'h0, irq}, 32'h1);
        rd_check(cycle_watch_pkg::FLAGS_OFS, 32'h1);
        // overrun, the earlier extend error and cycle ends are all still pending
        axi_read(cycle_watch_pkg::IRQ_STATUS_OFS, d, r);
        check(d, 32'h7);
        axi_write(cycle_watch_pkg::IRQ_STATUS_OFS, 32'h7, r);
        repeat (3) @(posedge clk_in);
        check({31'h0, irq}, 32'h0);
        start_cycle;
        check({31'h0, halt}, 32'h1);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        check({30'h0, halt, fatal}, 32'h0);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        t_reset_values;
        t_times;
        t_extend;
        t_overrun;
        end_of_test;
    end
endmodule
